// ### hw/asp_core.sv
`default_nettype none

// Behaviour
// - formatted store writes one to thirty-two bits
// - operands: start location, count 1 to 32
// - indexed store writes stack top word
// - offset added as plain binary number
// - indexed store clears accumulator upper half
// - back-to-back loads push first value
// - low byte store writes bits 7..0
// - middle byte store writes bits 15..8
// - pop moves 32-bit top into accumulator
// - pop advances remaining levels toward top
// - zero flag follows pop and AND16
// - AND16 combines low half with word
// - flag holds until next updating operation
// - AND32 sets zero and negative flags
module asp_core
    import asp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // operation request, taken on a rising edge of clk_sys with cmd_valid high
    input wire logic cmd_valid,
    input wire asp_op_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [CNT_W-1:0] cmd_count,
    input wire logic [ACC_W-1:0] cmd_value,
    // word memory write port
    output logic wmem_wr_en,
    output logic [ADDR_W-1:0] wmem_wr_addr,
    output logic [WORD_W-1:0] wmem_wr_data,
    output logic [1:0] wmem_wr_lanes,
    // discrete bit memory write port
    output logic bmem_wr_en,
    output logic [ADDR_W-1:0] bmem_wr_start,
    output logic [ACC_W-1:0] bmem_wr_bits,
    output logic [ACC_W-1:0] bmem_wr_mask,
    // state seen by the rest of the cpu
    output logic [ACC_W-1:0] acc_value,
    output logic [ACC_W-1:0] stack_top,
    output logic zero_result_flag,
    output logic negative_result_flag,
    output logic cmd_error
);

    // decoded requests
    logic do_load, do_fmt, do_idx, do_low, do_mid, do_pop, do_and16, do_and32, do_word;
    logic fmt_cnt_ok;
    // accumulator and load history
    logic [ACC_W-1:0] acc_ff, nxt_acc;
    logic last_load_ff, nxt_last_load;
    // flags
    logic zero_ff, nxt_zero, neg_ff, nxt_neg;
    // stack control
    logic stk_push, stk_pop;
    logic [ACC_W-1:0] stk_top;
    // write ports
    logic wmem_en_ff, nxt_wmem_en;
    logic [ADDR_W-1:0] wmem_addr_ff, nxt_wmem_addr;
    logic [WORD_W-1:0] wmem_data_ff, nxt_wmem_data;
    logic [1:0] wmem_lanes_ff, nxt_wmem_lanes;
    logic bmem_en_ff, nxt_bmem_en;
    logic [ADDR_W-1:0] bmem_start_ff, nxt_bmem_start;
    logic [ACC_W-1:0] bmem_bits_ff, nxt_bmem_bits;
    logic [ACC_W-1:0] bmem_mask_ff, nxt_bmem_mask;
    logic err_ff, nxt_err;
    // combinational helpers
    logic [ACC_W-1:0] fmt_mask;
    logic [ACC_W-1:0] and16_res, and32_res;

    // one strobe per operation; an unknown code decodes to nothing
    always_comb begin
        do_load = 1'b0;
        do_fmt = 1'b0;
        do_idx = 1'b0;
        do_low = 1'b0;
        do_mid = 1'b0;
        do_pop = 1'b0;
        do_and16 = 1'b0;
        do_and32 = 1'b0;
        do_word = 1'b0;
        if (cmd_valid) begin
            case (cmd_op)
                ASP_OP_LOAD: do_load = 1'b1;
                ASP_OP_FMT_STORE: do_fmt = 1'b1;
                ASP_OP_IDX_STORE: do_idx = 1'b1;
                ASP_OP_LOW_BYTE: do_low = 1'b1;
                ASP_OP_MID_BYTE: do_mid = 1'b1;
                ASP_OP_POP: do_pop = 1'b1;
                ASP_OP_AND16: do_and16 = 1'b1;
                ASP_OP_AND32: do_and32 = 1'b1;
                ASP_OP_WORD_STORE: do_word = 1'b1;
                default: do_load = 1'b0;
            endcase
        end
    end

    assign fmt_cnt_ok = (cmd_count >= FMT_CNT_MIN) && (cmd_count <= FMT_CNT_MAX);

    // bit enable mask
    // bit i of the accumulator goes to start + i while i is below the count
    for (genvar i = 0; i < ACC_W; i++) begin : g_mask
        assign fmt_mask[i] = (CNT_W'(i) < cmd_count);
    end

    assign and16_res = {{(ACC_W-WORD_W){1'b0}}, acc_ff[WORD_W-1:0] & cmd_value[WORD_W-1:0]};
    assign and32_res = acc_ff & cmd_value;

    // push on second load in a row
    // the stack only moves on a load that follows a load, or on a pop
    assign stk_push = do_load && last_load_ff;
    assign stk_pop = do_pop;

    // accumulator stack, top level registered
    asp_stack u_stack (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(acc_ff),
        .top_data(stk_top)
    );

    // accumulator, load history and flags
    always_comb begin
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        nxt_neg = neg_ff;
        nxt_last_load = last_load_ff;
        nxt_err = 1'b0;
        if (cmd_valid) begin
            // idle cycles do not break a run of loads
            nxt_last_load = do_load;
        end
        if (do_load) begin
            nxt_acc = cmd_value;
        end else if (do_idx) begin
            nxt_acc = {{(ACC_W-WORD_W){1'b0}}, acc_ff[WORD_W-1:0]};
        end else if (do_pop) begin
            nxt_acc = stk_top;
            nxt_zero = (stk_top == ACC_RST);
        end else if (do_and16) begin
            nxt_acc = and16_res;
            nxt_zero = (and16_res == ACC_RST);
        end else if (do_and32) begin
            nxt_acc = and32_res;
            nxt_zero = (and32_res == ACC_RST);
            nxt_neg = and32_res[ACC_W-1];
        end else if (do_fmt && !fmt_cnt_ok) begin
            // a bad count writes nothing; flagged for one cycle
            nxt_err = 1'b1;
        end
    end

    // register accumulator and flags
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc_ff <= ACC_RST;
            zero_ff <= 1'b0;
            neg_ff <= 1'b0;
            last_load_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            zero_ff <= nxt_zero;
            neg_ff <= nxt_neg;
            last_load_ff <= nxt_last_load;
            err_ff <= nxt_err;
        end
    end

    // word memory and bit memory writes, one cycle after the request
    always_comb begin
        nxt_wmem_en = 1'b0;
        nxt_wmem_addr = wmem_addr_ff;
        nxt_wmem_data = wmem_data_ff;
        nxt_wmem_lanes = LANES_NONE;
        nxt_bmem_en = 1'b0;
        nxt_bmem_start = bmem_start_ff;
        nxt_bmem_bits = bmem_bits_ff;
        nxt_bmem_mask = bmem_mask_ff;
        if (do_idx) begin
            // binary offset add, wraps in the address width
            nxt_wmem_en = 1'b1;
            nxt_wmem_addr = cmd_addr + acc_ff[ADDR_W-1:0];
            nxt_wmem_data = stk_top[WORD_W-1:0];
            nxt_wmem_lanes = LANES_BOTH;
        end else if (do_low) begin
            nxt_wmem_en = 1'b1;
            nxt_wmem_addr = cmd_addr;
            nxt_wmem_data = {{(WORD_W-BYTE_W){1'b0}}, acc_ff[BYTE_W-1:0]};
            nxt_wmem_lanes = LANES_LOW;
        end else if (do_mid) begin
            nxt_wmem_en = 1'b1;
            nxt_wmem_addr = cmd_addr;
            nxt_wmem_data = {{(WORD_W-BYTE_W){1'b0}}, acc_ff[WORD_W-1:BYTE_W]};
            nxt_wmem_lanes = LANES_LOW;
        end else if (do_word) begin
            // plain word store of the low half
            nxt_wmem_en = 1'b1;
            nxt_wmem_addr = cmd_addr;
            nxt_wmem_data = acc_ff[WORD_W-1:0];
            nxt_wmem_lanes = LANES_BOTH;
        end else if (do_fmt && fmt_cnt_ok) begin
            nxt_bmem_en = 1'b1;
            nxt_bmem_start = cmd_addr;
            nxt_bmem_bits = acc_ff;
            nxt_bmem_mask = fmt_mask;
        end
    end

    // register the write ports so memory sees clean data
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wmem_en_ff <= 1'b0;
            wmem_addr_ff <= ADDR_RST;
            wmem_data_ff <= WORD_RST;
            wmem_lanes_ff <= LANES_NONE;
            bmem_en_ff <= 1'b0;
            bmem_start_ff <= ADDR_RST;
            bmem_bits_ff <= ACC_RST;
            bmem_mask_ff <= ACC_RST;
        end else begin
            wmem_en_ff <= nxt_wmem_en;
            wmem_addr_ff <= nxt_wmem_addr;
            wmem_data_ff <= nxt_wmem_data;
            wmem_lanes_ff <= nxt_wmem_lanes;
            bmem_en_ff <= nxt_bmem_en;
            bmem_start_ff <= nxt_bmem_start;
            bmem_bits_ff <= nxt_bmem_bits;
            bmem_mask_ff <= nxt_bmem_mask;
        end
    end
    // outputs
    assign wmem_wr_en = wmem_en_ff;
    assign wmem_wr_addr = wmem_addr_ff;
    assign wmem_wr_data = wmem_data_ff;
    assign wmem_wr_lanes = wmem_lanes_ff;
    assign bmem_wr_en = bmem_en_ff;
    assign bmem_wr_start = bmem_start_ff;
    assign bmem_wr_bits = bmem_bits_ff;
    assign bmem_wr_mask = bmem_mask_ff;
    assign acc_value = acc_ff;
    assign stack_top = stk_top;
    assign zero_result_flag = zero_ff;
    assign negative_result_flag = neg_ff;
    assign cmd_error = err_ff;
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_two_loads;
        do_load ##1 do_load;
    endsequence
    sequence s_pop_then_pop;
        do_pop ##1 do_pop;
    endsequence
    a_fmt_store_write: assert property (
        do_fmt && fmt_cnt_ok |=> bmem_wr_en && bmem_wr_bits == $past(acc_ff)
            && bmem_wr_start == $past(cmd_addr))
        else $error("formatted store did not write");
    a_fmt_mask_count: assert property (
        do_fmt && fmt_cnt_ok |=> $countones(bmem_wr_mask) == int'($past(cmd_count))
            && bmem_wr_mask[0])
        else $error("formatted store mask wrong");
    a_fmt_bad_count: assert property (
        do_fmt && !fmt_cnt_ok |=> !bmem_wr_en && cmd_error)
        else $error("bad bit count not refused");
    a_idx_store_word: assert property (
        do_idx |=> wmem_wr_en && wmem_wr_data == $past(stk_top[WORD_W-1:0])
            && wmem_wr_lanes == LANES_BOTH)
        else $error("indexed store data wrong");
    a_idx_store_addr: assert property (
        do_idx |=> wmem_wr_addr == ADDR_W'($past(cmd_addr) + $past(acc_ff[ADDR_W-1:0])))
        else $error("indexed store address wrong");
    a_idx_clear_upper: assert property (
        do_idx |=> acc_ff[ACC_W-1:WORD_W] == '0
            && acc_ff[WORD_W-1:0] == $past(acc_ff[WORD_W-1:0]))
        else $error("indexed store left upper half");
    a_load_push: assert property (
        s_two_loads |=> stk_top == $past(acc_ff) && acc_ff == $past(cmd_value))
        else $error("load did not push first value");
    a_low_byte: assert property (
        do_low |=> wmem_wr_en && wmem_wr_lanes == LANES_LOW
            && wmem_wr_data[BYTE_W-1:0] == $past(acc_ff[BYTE_W-1:0]))
        else $error("low byte store wrong");
    a_mid_byte: assert property (
        do_mid |=> wmem_wr_en && wmem_wr_data[BYTE_W-1:0] == $past(acc_ff[WORD_W-1:BYTE_W]))
        else $error("middle byte store wrong");
    a_pop_levels: assert property (
        s_pop_then_pop |=> acc_ff == $past(stk_top) && $past(acc_ff) == $past(stk_top, 2))
        else $error("pop did not advance stack");
    // zero flag after pop or and16
    a_zero_flag: assert property (
        do_pop || do_and16 |=> zero_result_flag == (acc_ff == ACC_RST))
        else $error("zero flag wrong");
    a_and16_result: assert property (
        do_and16 |=> acc_ff[WORD_W-1:0]
            == ($past(acc_ff[WORD_W-1:0]) & $past(cmd_value[WORD_W-1:0])))
        else $error("and16 result wrong");
    a_flag_hold: assert property (
        !(do_pop || do_and16 || do_and32) |=> $stable(zero_result_flag)
            && $stable(negative_result_flag))
        else $error("flag changed without update");
    a_and32_flags: assert property (
        do_and32 |=> negative_result_flag == acc_ff[ACC_W-1]
            && zero_result_flag == (acc_ff == ACC_RST))
        else $error("and32 flags wrong");
endmodule // asp_core

`default_nettype wire

// ### hw/asp_pkg.sv
`default_nettype none

package asp_pkg;

    // datapath widths
    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam int CNT_W = 6;
    localparam int STK_DEPTH = 8;

    // legal bit counts for the formatted bit store
    localparam logic [CNT_W-1:0] FMT_CNT_MIN = 6'h01;
    localparam logic [CNT_W-1:0] FMT_CNT_MAX = 6'h20;

    // values after reset
    localparam logic [ACC_W-1:0] ACC_RST = 32'h00000000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

    // word memory byte lanes
    localparam logic [1:0] LANES_NONE = 2'h0;
    localparam logic [1:0] LANES_LOW = 2'h1;
    localparam logic [1:0] LANES_BOTH = 2'h3;

    // operation codes, one-hot
    typedef enum logic [8:0] {
        ASP_OP_LOAD = 9'h001,
        ASP_OP_FMT_STORE = 9'h002,
        ASP_OP_IDX_STORE = 9'h004,
        ASP_OP_LOW_BYTE = 9'h008,
        ASP_OP_MID_BYTE = 9'h010,
        ASP_OP_POP = 9'h020,
        ASP_OP_AND16 = 9'h040,
        ASP_OP_AND32 = 9'h080,
        ASP_OP_WORD_STORE = 9'h100
    } asp_op_t;

endpackage

`default_nettype wire

// ### hw/asp_stack.sv
`default_nettype none

// accumulator stack: level 0 is the top, held in a register so the read is registered
module asp_stack
    import asp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // stack control
    input wire logic push,
    input wire logic pop,
    input wire logic [ACC_W-1:0] push_data,
    // top level
    output logic [ACC_W-1:0] top_data
);

    // stack levels and their next values
    logic [ACC_W-1:0] lvl_ff [STK_DEPTH];
    logic [ACC_W-1:0] nxt_lvl [STK_DEPTH];

    // per level: push shifts down, pop shifts up, bottom refills with zero
    for (genvar i = 0; i < STK_DEPTH; i++) begin : g_lvl
        logic [ACC_W-1:0] above;
        logic [ACC_W-1:0] below;
        if (i == 0) begin : g_top
            assign above = push_data;
        end else begin : g_mid
            assign above = lvl_ff[i-1];
        end
        if (i == STK_DEPTH - 1) begin : g_bot
            assign below = ACC_RST;
        end else begin : g_up
            assign below = lvl_ff[i+1];
        end

        // push wins if both arrive; the core never asks for both
        always_comb begin
            if (push) begin
                nxt_lvl[i] = above;
            end else if (pop) begin
                nxt_lvl[i] = below;
            end else begin
                nxt_lvl[i] = lvl_ff[i];
            end
        end

        // register the level
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                lvl_ff[i] <= ACC_RST;
            end else begin
                lvl_ff[i] <= nxt_lvl[i];
            end
        end
    end

    assign top_data = lvl_ff[0];

endmodule // asp_stack

`default_nettype wire

// ### verif/asp_mem_model.sv
`default_nettype none

// behavioural word and bit memory facing the core's write ports
module asp_mem_model
    import asp_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // word memory write port
    input wire logic wmem_wr_en,
    input wire logic [ADDR_W-1:0] wmem_wr_addr,
    input wire logic [WORD_W-1:0] wmem_wr_data,
    input wire logic [1:0] wmem_wr_lanes,
    // bit memory write port
    input wire logic bmem_wr_en,
    input wire logic [ADDR_W-1:0] bmem_wr_start,
    input wire logic [ACC_W-1:0] bmem_wr_bits,
    input wire logic [ACC_W-1:0] bmem_wr_mask
);
    timeunit 1ns;
    timeprecision 1ps;

    // storage starts all ones so untouched lanes and bits stand out
    logic [WORD_W-1:0] words [0:65535];
    logic bits_mem [0:65535];

    initial begin
        for (int i = 0; i < 65536; i++) begin
            words[i] = 16'hFFFF;
            bits_mem[i] = 1'b1;
        end
    end

    // capture writes at the edge where the strobes are seen
    always @(posedge clk_sys) begin
        if (wmem_wr_en === 1'b1) begin
            // each lane only touches its own byte
            if (wmem_wr_lanes[0]) words[wmem_wr_addr][7:0] <= wmem_wr_data[7:0];
            if (wmem_wr_lanes[1]) words[wmem_wr_addr][15:8] <= wmem_wr_data[15:8];
        end
        if (bmem_wr_en === 1'b1) begin
            // bit i lands at start plus i, wrapping in the bit space
            for (int i = 0; i < ACC_W; i++) begin
                if (bmem_wr_mask[i]) bits_mem[ADDR_W'(bmem_wr_start + i)] <= bmem_wr_bits[i];
            end
        end
    end
endmodule // asp_mem_model

`default_nettype wire

// ### verif/accumulator_store_pop_and_unit_tb_top.sv
`default_nettype none

`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module accumulator_store_pop_and_unit_tb_top
    import asp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset and request
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    asp_op_t cmd_op = ASP_OP_LOAD;
    logic [ADDR_W-1:0] cmd_addr = 16'h0000;
    logic [CNT_W-1:0] cmd_count = 6'h00;
    logic [ACC_W-1:0] cmd_value = 32'h00000000;
    // design outputs
    logic wmem_wr_en, bmem_wr_en, zero_result_flag, negative_result_flag, cmd_error;
    logic [ADDR_W-1:0] wmem_wr_addr, bmem_wr_start;
    logic [WORD_W-1:0] wmem_wr_data;
    logic [1:0] wmem_wr_lanes;
    logic [ACC_W-1:0] bmem_wr_bits, bmem_wr_mask, acc_value, stack_top;
    // bookkeeping
    int miscompares = 0;
    int checks_done = 0;

    always #25 clk_sys = ~clk_sys;

    asp_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_value(cmd_value),
        .wmem_wr_en(wmem_wr_en), .wmem_wr_addr(wmem_wr_addr), .wmem_wr_data(wmem_wr_data),
        .wmem_wr_lanes(wmem_wr_lanes), .bmem_wr_en(bmem_wr_en), .bmem_wr_start(bmem_wr_start),
        .bmem_wr_bits(bmem_wr_bits), .bmem_wr_mask(bmem_wr_mask), .acc_value(acc_value),
        .stack_top(stack_top), .zero_result_flag(zero_result_flag),
        .negative_result_flag(negative_result_flag), .cmd_error(cmd_error));

    asp_mem_model mem (.clk_sys(clk_sys), .wmem_wr_en(wmem_wr_en), .wmem_wr_addr(wmem_wr_addr),
        .wmem_wr_data(wmem_wr_data), .wmem_wr_lanes(wmem_wr_lanes), .bmem_wr_en(bmem_wr_en),
        .bmem_wr_start(bmem_wr_start), .bmem_wr_bits(bmem_wr_bits), .bmem_wr_mask(bmem_wr_mask));

    // one request on a falling edge, released a cycle later; results are then settled
    task automatic issue(input asp_op_t op, input logic [ADDR_W-1:0] a,
                         input logic [CNT_W-1:0] n, input logic [ACC_W-1:0] v);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_count = n;
        cmd_value = v;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask

    // three loads stack up, three pops drain them
    task automatic scen_load_pop();
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'h11111111);
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'h22222222);
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'h33333333);
        `CHK("acc", 32'h33333333, acc_value)
        `CHK("top", 32'h22222222, stack_top)
        issue(ASP_OP_POP, 16'h0000, 6'h00, 32'h00000000);
        `CHK("acc", 32'h22222222, acc_value)
        `CHK("top", 32'h11111111, stack_top)
        `CHK("zero", 1'b0, zero_result_flag)
        issue(ASP_OP_POP, 16'h0000, 6'h00, 32'h00000000);
        issue(ASP_OP_POP, 16'h0000, 6'h00, 32'h00000000);
        `CHK("acc", 32'h00000000, acc_value)
        `CHK("zero", 1'b1, zero_result_flag)
    endtask

    // indexed store with an address that wraps past the top
    task automatic scen_idx();
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'h00003544);
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'hABCD0015);
        issue(ASP_OP_IDX_STORE, 16'hFFF0, 6'h00, 32'h00000000);
        `CHK("wen", 1'b1, wmem_wr_en)
        `CHK("waddr", 16'h0005, wmem_wr_addr)
        `CHK("wdata", 16'h3544, wmem_wr_data)
        `CHK("lanes", LANES_BOTH, wmem_wr_lanes)
        `CHK("acc", 32'h00000015, acc_value)
        @(negedge clk_sys);
        `CHK("wen", 1'b0, wmem_wr_en)
        `CHK("mem", 16'h3544, mem.words[5])
    endtask

    // byte stores leave the other half of the word alone
    task automatic scen_bytes();
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'h1234A5C3);
        issue(ASP_OP_LOW_BYTE, 16'h0100, 6'h00, 32'h00000000);
        `CHK("lanes", LANES_LOW, wmem_wr_lanes)
        issue(ASP_OP_MID_BYTE, 16'h0101, 6'h00, 32'h00000000);
        `CHK("wdata", 16'h00A5, wmem_wr_data)
        @(negedge clk_sys);
        `CHK("low", 16'hFFC3, mem.words[16'h0100])
        `CHK("mid", 16'hFFA5, mem.words[16'h0101])
    endtask

    // formatted store at the boundary counts, then illegal counts refused
    task automatic scen_fmt();
        logic [CNT_W-1:0] cnts [3];
        logic [ADDR_W-1:0] s;
        logic [63:0] m;
        logic [ACC_W-1:0] pat;
        cnts = '{6'h01, 6'h07, 6'h20};
        pat = 32'h70000055;
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'h70000055);
        for (int i = 0; i < 3; i++) begin
            s = 16'h0200 + 16'(i * 64);
            m = (64'h1 << cnts[i]) - 64'h1;
            issue(ASP_OP_FMT_STORE, s, cnts[i], 32'h00000000);
            `CHK("ben", 1'b1, bmem_wr_en)
            `CHK("start", s, bmem_wr_start)
            `CHK("mask", m[31:0], bmem_wr_mask)
            `CHK("bits", 32'h70000055, bmem_wr_bits)
            @(negedge clk_sys);
            `CHK("last", pat[cnts[i] - 6'h01], mem.bits_mem[s + cnts[i] - 16'h0001])
            `CHK("past", 1'b1, mem.bits_mem[s + cnts[i]])
        end
        issue(ASP_OP_FMT_STORE, 16'h0400, 6'h00, 32'h00000000);
        `CHK("err", 1'b1, cmd_error)
        `CHK("ben", 1'b0, bmem_wr_en)
        issue(ASP_OP_FMT_STORE, 16'h0400, 6'h21, 32'h00000000);
        `CHK("err", 1'b1, cmd_error)
    endtask

    // and operations and how long their flags stand
    task automatic scen_and();
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'h80000001);
        issue(ASP_OP_AND32, 16'h0000, 6'h00, 32'hF0000000);
        `CHK("acc", 32'h80000000, acc_value)
        `CHK("neg", 1'b1, negative_result_flag)
        `CHK("zero", 1'b0, zero_result_flag)
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'hFFFFF0F0);
        `CHK("neg", 1'b1, negative_result_flag)
        issue(ASP_OP_AND16, 16'h0000, 6'h00, 32'h00000F0F);
        `CHK("acc", 32'h00000000, acc_value)
        `CHK("zero", 1'b1, zero_result_flag)
        `CHK("neg", 1'b1, negative_result_flag)
        issue(ASP_OP_LOAD, 16'h0000, 6'h00, 32'hFFFF00FF);
        issue(ASP_OP_AND16, 16'h0000, 6'h00, 32'h1234FF0F);
        `CHK("acc", 32'h0000000F, acc_value)
        `CHK("zero", 1'b0, zero_result_flag)
    endtask

    // loads and pops on consecutive edges, then a plain word store of the low half
    task automatic scen_back_to_back();
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_op = ASP_OP_LOAD;
        cmd_value = 32'hA5A50001;
        @(negedge clk_sys);
        cmd_value = 32'h5A5A0002;
        @(negedge clk_sys);
        `CHK("acc", 32'h5A5A0002, acc_value)
        `CHK("top", 32'hA5A50001, stack_top)
        cmd_op = ASP_OP_POP;
        @(negedge clk_sys);
        @(negedge clk_sys);
        `CHK("acc", 32'h00003544, acc_value)
        `CHK("top", 32'h00000000, stack_top)
        `CHK("zero", 1'b0, zero_result_flag)
        cmd_op = ASP_OP_WORD_STORE;
        cmd_addr = 16'h0300;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        `CHK("wen", 1'b1, wmem_wr_en)
        `CHK("waddr", 16'h0300, wmem_wr_addr)
        `CHK("wdata", 16'h3544, wmem_wr_data)
        `CHK("lanes", LANES_BOTH, wmem_wr_lanes)
        @(negedge clk_sys);
        `CHK("word", 16'h3544, mem.words[16'h0300])
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: the run is short, so a long stall means a hang
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        `CHK("acc", ACC_RST, acc_value)
        `CHK("top", ACC_RST, stack_top)
        scen_load_pop();
        scen_idx();
        scen_bytes();
        scen_fmt();
        scen_and();
        scen_back_to_back();
        final_report();
    end
endmodule // accumulator_store_pop_and_unit_tb_top

`default_nettype wire
